/* File: hdl/ltsd_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - thermal start point code picks 140, 120, 100 or 90 degrees
// - derate code limits current to 100, 75, 55 or 30 percent
// - over-temperature flag reads one while die is above start point
// - without dc mode outputs follow latched duty, up to one step below full
// - a duty of one step gives no on-time
// - dc mode disables dimming; current scales alone set brightness
// - dc bit 0,1,2 forces outputs 1-6, 7-12, 13-18 on
// - spread enable bit turns oscillator sweep on or off
// - spread period code selects 1980, 1200, 820 or 660 us
// - spread span code selects 5, 15, 24 or 34 percent deviation
// - power-on clears every register to zero
// - writing zero to the reset address clears every register
// - global scale lowers all currents; per-channel scales set each one
// - duty counters run with 256, 1024, 4096 or 65536 steps
// - duty takes effect after update write, pin high and shutdown released
// - default 8-bit dimming near 62 kHz from a 16 MHz step rate
module ltsd_ctrl #(
	parameter int SPREAD_CYC_0 = ltsd_pkg::PERIOD_US[0] * ltsd_pkg::CLK_MHZ,
	parameter int SPREAD_CYC_1 = ltsd_pkg::PERIOD_US[1] * ltsd_pkg::CLK_MHZ,
	parameter int SPREAD_CYC_2 = ltsd_pkg::PERIOD_US[2] * ltsd_pkg::CLK_MHZ,
	parameter int SPREAD_CYC_3 = ltsd_pkg::PERIOD_US[3] * ltsd_pkg::CLK_MHZ
) (
	// clock, reset, enable
	input  wire logic               mclk_in,
	input  wire logic               rst_in,
	input  wire logic               ce_in,
	// register port
	input  wire ltsd_pkg::ltsd_req_t req_in,
	output ltsd_pkg::ltsd_rsp_t     rsp_out,
	output logic                    busy_out,
	// pins and sensor
	input  wire logic               shutdown_pin_in,
	input  wire logic [7:0]         die_temp_in,
	// channel drive
	output logic [17:0]             out_a_out,
	output logic [17:0]             out_b_out,
	output logic [7:0]              global_current_out,
	output ltsd_pkg::ltsd_scale_t   chan_scale_out,
	output logic                    over_temp_out,
	// oscillator control
	output logic                    osc_tick_out,
	output logic signed [11:0]      osc_trim_out
);
	import ltsd_pkg::*;

	localparam int PER_CYC [4] = '{SPREAD_CYC_0, SPREAD_CYC_1, SPREAD_CYC_2, SPREAD_CYC_3};

	ltsd_state_t state;
	logic [6:0]  clr_addr;
	logic [8:0]  sync1, sync2, sync3, in_q;
	logic [7:0]  ctrl, gscale, temp_reg, spread;
	logic [7:0]  rda, rdb;
	logic        rd_pend;
	logic [7:0]  rd_addr;
	logic        commit_arm, copying;
	logic [6:0]  sa, sa_d;
	logic [7:0]  sla;
	logic [7:0]  act [4*NUM_CH];
	logic [12:0] acc;
	logic [15:0] cnt;
	logic [16:0] err;
	logic        up;

	// decode
	wire        clearing  = (state == ST_CLEAR);
	wire        wr_run    = ce_in && !clearing && req_in.wr;
	wire        pin_high  = in_q[8];
	wire [7:0]  temp_now  = in_q[7:0];
	wire        run_ok    = ctrl[CTRL_RUN_BIT] && pin_high;
	wire        upd_take  = wr_run && req_in.addr == ADDR_UPDATE && req_in.wdata == TRIGGER
	                        && run_ok;
	wire        rst_take  = wr_run && req_in.addr == ADDR_SWRST && req_in.wdata == TRIGGER;
	wire        mem_wen   = clearing || (wr_run && !req_in.addr[7] && req_in.addr != ADDR_SWRST);
	wire [6:0]  mem_waddr = clearing ? clr_addr : req_in.addr[6:0];
	wire [7:0]  mem_wdata = clearing ? RST_VAL : req_in.wdata;
	wire [1:0]  res       = ctrl[CTRL_RES_LSB +: 2];
	wire [15:0] mask      = 16'((32'h1 << RES_BITS[res]) - 1);
	wire        sweep_st  = (sa == ADDR_PWM_FIRST[6:0]);
	wire        sd_pwm    = {1'b0, sa_d} >= ADDR_PWM_FIRST && {1'b0, sa_d} <= ADDR_PWM_LAST;
	wire        sd_lvl    = {1'b0, sa_d} >= ADDR_LVL_FIRST && {1'b0, sa_d} <= ADDR_LVL_LAST;
	wire [6:0]  lvl_off   = sa_d - ADDR_LVL_FIRST[6:0];
	wire        spr_en    = spread[SPR_EN_BIT];
	wire [11:0] span      = 12'(SPAN_PCT[spread[SPR_SPAN_LSB +: 2]] * ACC_BASE / 100);
	wire [16:0] per       = 17'(PER_CYC[spread[SPR_PERIOD_LSB +: 2]]);
	wire [17:0] err_sum   = 18'(err) + 18'({span, 2'b00});
	wire        step      = err_sum >= 18'(per);
	wire [13:0] acc_sum   = 14'(acc) + 14'(ACC_BASE) + 14'(osc_trim_out);
	wire        tick      = acc_sum >= 14'(ACC_MOD);
	wire        hot       = temp_now > START_C[temp_reg[TEMP_START_LSB +: 2]];
	wire [16:0] derated   = 17'(gscale) * 17'(DERATE_MUL[temp_reg[TEMP_DERATE_LSB +: 2]]);
	wire [7:0]  temp_view = {temp_reg[7:6], 1'b0, over_temp_out, 2'b00, temp_reg[1:0]};
	wire [7:0]  rd_view   = (rd_addr[7] || rd_addr == ADDR_SWRST) ? 8'h00 :
	                        (rd_addr == ADDR_TEMP) ? temp_view : rda;
	logic [17:0] next_out_a, next_out_b;

	ltsd_regmem u_mem (
		.mclk_in       (mclk_in),
		.ce_in         (ce_in),
		.wr_en_in      (mem_wen),
		.wr_addr_in    (mem_waddr),
		.wr_data_in    (mem_wdata),
		.rd_a_addr_in  (req_in.addr[6:0]),
		.rd_a_data_out (rda),
		.rd_b_addr_in  (sa),
		.rd_b_data_out (rdb)
	);

	// pin and sensor capture; the word moves only when stages two and three agree
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			sync1 <= 9'h000;
			sync2 <= 9'h000;
			sync3 <= 9'h000;
			in_q  <= 9'h000;
		end else if (ce_in) begin
			sync1 <= {shutdown_pin_in, die_temp_in};
			sync2 <= sync1;
			sync3 <= sync2;
			if (sync2 == sync3) begin
				in_q <= sync3;
			end
		end
	end

	// clear walk after power-on and after a reset write
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state    <= ST_CLEAR;
			clr_addr <= 7'h00;
			busy_out <= 1'b1;
		end else if (ce_in) begin
			case (state)
				ST_CLEAR: begin
					clr_addr <= clr_addr + 7'h01;
					if (clr_addr == 7'h7f) begin
						state    <= ST_RUN;
						busy_out <= 1'b0;
					end
				end
				ST_RUN: begin
					if (rst_take) begin
						state    <= ST_CLEAR;
						clr_addr <= 7'h00;
						busy_out <= 1'b1;
					end
				end
				default: begin
					state    <= ST_CLEAR;
					busy_out <= 1'b1;
				end
			endcase
		end
	end

	// control copies that steer the logic directly
	always_ff @(posedge mclk_in) begin
		if (rst_in || (ce_in && clearing)) begin
			ctrl     <= RST_VAL;
			gscale   <= RST_VAL;
			temp_reg <= RST_VAL;
			spread   <= RST_VAL;
		end else if (wr_run) begin
			if (req_in.addr == ADDR_CTRL) ctrl <= req_in.wdata;
			if (req_in.addr == ADDR_GLOBAL) gscale <= req_in.wdata;
			if (req_in.addr == ADDR_TEMP) temp_reg <= req_in.wdata;
			if (req_in.addr == ADDR_SPREAD) spread <= req_in.wdata;
		end
	end

	// read answer two cycles after the request; the flag is live, not stored
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			rd_pend <= 1'b0;
			rd_addr <= 8'h00;
			rsp_out <= '0;
		end else if (ce_in) begin
			rd_pend       <= req_in.rd;
			rd_addr       <= req_in.addr;
			rsp_out.valid <= rd_pend;
			rsp_out.data  <= rd_view;
		end
	end

	// update arming; a new arm in the sweep-start cycle survives
	always_ff @(posedge mclk_in) begin
		if (rst_in || (ce_in && clearing)) begin
			commit_arm <= 1'b0;
			copying    <= 1'b0;
		end else if (ce_in) begin
			commit_arm <= upd_take || (commit_arm && !sweep_st);
			if (sweep_st) begin
				copying <= commit_arm;
			end
		end
	end

	// background sweep over duty shadows and scale registers
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			sa             <= ADDR_PWM_FIRST[6:0];
			sa_d           <= 7'h00;
			sla            <= 8'h00;
			chan_scale_out <= '0;
		end else if (ce_in) begin
			sa   <= (sa == ADDR_LVL_LAST[6:0]) ? ADDR_PWM_FIRST[6:0] : sa + 7'h01;
			sa_d <= sa;
			if (sd_lvl && !lvl_off[0]) begin
				sla <= rdb;
			end
			chan_scale_out.valid <= sd_lvl && lvl_off[0];
			chan_scale_out.idx   <= lvl_off[5:1];
			chan_scale_out.level <= {1'b0, sla} + {1'b0, rdb};
		end
	end

	// latched duty bytes, loaded only by a committed sweep
	genvar i;
	generate
		for (i = 0; i < 4 * NUM_CH; i++) begin : g_act
			always_ff @(posedge mclk_in) begin
				if (rst_in || (ce_in && clearing)) begin
					act[i] <= RST_VAL;
				end else if (ce_in && copying && sd_pwm && sa_d == 7'(i + 1)) begin
					act[i] <= rdb;
				end
			end
		end
	endgenerate

	// 16 MHz average step rate from 50 MHz, bent by the spread trim
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			acc          <= 13'h0000;
			cnt          <= 16'h0000;
			osc_tick_out <= 1'b0;
		end else if (ce_in) begin
			acc          <= tick ? 13'(acc_sum - 14'(ACC_MOD)) : acc_sum[12:0];
			osc_tick_out <= tick;
			if (tick) begin
				cnt <= (cnt + 16'h0001) & mask;
			end
		end
	end

	// triangle sweep: one trim step whenever the error crosses the period
	always_ff @(posedge mclk_in) begin
		if (rst_in || (ce_in && !spr_en)) begin
			err          <= 17'h00000;
			osc_trim_out <= 12'sh000;
			up           <= 1'b1;
		end else if (ce_in) begin
			err <= step ? 17'(err_sum - 18'(per)) : err_sum[16:0];
			if (step) begin
				if (up && osc_trim_out >= $signed(span)) begin
					up           <= 1'b0;
					osc_trim_out <= osc_trim_out - 12'sh001;
				end else if (!up && osc_trim_out <= -$signed(span)) begin
					up           <= 1'b1;
					osc_trim_out <= osc_trim_out + 12'sh001;
				end else begin
					osc_trim_out <= up ? osc_trim_out + 12'sh001 : osc_trim_out - 12'sh001;
				end
			end
		end
	end

	// per-channel compare; a duty of exactly one stays dark
	generate
		for (i = 0; i < NUM_CH; i++) begin : g_ch
			wire        dc     = spread[SPR_DC_LSB + i / GROUP_CH];
			wire [15:0] duty_a = (res == 2'b00) ? {8'h00, act[4*i]} :
			                     ({act[4*i+1], act[4*i]} & mask);
			wire [15:0] duty_b = (res == 2'b00) ? {8'h00, act[4*i+2]} :
			                     ({act[4*i+3], act[4*i+2]} & mask);
			assign next_out_a[i] = run_ok && (dc || (duty_a > cnt && duty_a != 16'h0001));
			assign next_out_b[i] = run_ok && (dc || (duty_b > cnt && duty_b != 16'h0001));
		end
	endgenerate

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			out_a_out          <= 18'h00000;
			out_b_out          <= 18'h00000;
			over_temp_out      <= 1'b0;
			global_current_out <= 8'h00;
		end else if (ce_in) begin
			out_a_out          <= next_out_a;
			out_b_out          <= next_out_b;
			over_temp_out      <= hot;
			global_current_out <= over_temp_out ? derated[15:8] : gscale;
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	sequence s_reset_write;
		ce_in && state == ST_RUN && req_in.wr && req_in.addr == ADDR_SWRST
		&& req_in.wdata == TRIGGER;
	endsequence

	sequence s_update_write;
		ce_in && state == ST_RUN && req_in.wr && req_in.addr == ADDR_UPDATE
		&& req_in.wdata == TRIGGER && run_ok;
	endsequence

	a_swreset_clear_walk: assert property (s_reset_write |=> busy_out && clr_addr == 7'h00)
		else $error("reset write did not start the clear walk");

	a_por_clear_walk: assert property (@(posedge mclk_in) disable iff (1'b0) rst_in |=> busy_out && ctrl == 8'h00 && spread == 8'h00)
		else $error("reset did not clear the registers");

	a_update_arms: assert property (s_update_write |=> commit_arm)
		else $error("update write did not arm the commit");

	a_flag_tracks_temp: assert property (ce_in ##1 ce_in |-> over_temp_out == $past(hot))
		else $error("over-temperature flag does not follow the die temperature");

	a_cool_full_scale: assert property (ce_in && !over_temp_out |=> global_current_out == $past(gscale))
		else $error("current derated while cool");

	a_dc_group_on: assert property (ce_in && run_ok && spread[SPR_DC_LSB] |=> out_a_out[0] && out_b_out[5])
		else $error("dc mode did not force its group on");

	a_dark_when_off: assert property (ce_in && !run_ok |=> out_a_out == 18'h00000 && out_b_out == 18'h00000)
		else $error("outputs lit during shutdown");

	a_min_step_dark: assert property (ce_in && res == 2'b00 && act[0] == 8'h01 && !spread[SPR_DC_LSB] |=> !out_a_out[0])
		else $error("single duty step produced on-time");

	a_spread_off_trim: assert property (ce_in && !spr_en |=> osc_trim_out == 12'sh000 ##1 !spr_en [*2] |-> osc_trim_out == 12'sh000)
		else $error("trim moved with spread disabled");

	a_scale_index: assert property (chan_scale_out.valid |-> chan_scale_out.idx < 5'h12)
		else $error("scale report for a missing channel");
endmodule

/* File: hdl/ltsd_pkg.sv */
package ltsd_pkg;

	// clocking of the block and of the emulated dimming oscillator
	localparam int CLK_MHZ  = 50;
	localparam int OSC_MHZ  = 16;
	localparam int ACC_MOD  = CLK_MHZ * 100;
	localparam int ACC_BASE = OSC_MHZ * 100;

	// register offsets
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_PWM_FIRST = 8'h01;
	localparam logic [7:0] ADDR_PWM_LAST  = 8'h48;
	localparam logic [7:0] ADDR_UPDATE    = 8'h49;
	localparam logic [7:0] ADDR_LVL_FIRST = 8'h4a;
	localparam logic [7:0] ADDR_LVL_LAST  = 8'h6d;
	localparam logic [7:0] ADDR_GLOBAL    = 8'h6e;
	localparam logic [7:0] ADDR_TEMP      = 8'h77;
	localparam logic [7:0] ADDR_SPREAD    = 8'h78;
	localparam logic [7:0] ADDR_SWRST     = 8'h7f;
	localparam logic [7:0] RST_VAL        = 8'h00;
	localparam logic [7:0] TRIGGER        = 8'h00;

	// field positions
	localparam int CTRL_RUN_BIT    = 0;
	localparam int CTRL_RES_LSB    = 1;
	localparam int TEMP_START_LSB  = 0;
	localparam int TEMP_FLAG_BIT   = 4;
	localparam int TEMP_DERATE_LSB = 6;
	localparam int SPR_PERIOD_LSB  = 0;
	localparam int SPR_SPAN_LSB    = 2;
	localparam int SPR_EN_BIT      = 4;
	localparam int SPR_DC_LSB      = 5;

	// channel layout
	localparam int NUM_CH   = 18;
	localparam int GROUP_CH = 6;
	localparam int DUTY_W   = 16;

	// code tables, index is the field code
	localparam logic [7:0] START_C    [4] = '{8'h8c, 8'h78, 8'h64, 8'h5a};
	localparam logic [8:0] DERATE_MUL [4] = '{9'h100, 9'h0c0, 9'h08d, 9'h04d};
	localparam int         RES_BITS   [4] = '{8, 10, 12, 16};
	localparam int         SPAN_PCT   [4] = '{5, 15, 24, 34};
	localparam int         PERIOD_US  [4] = '{1980, 1200, 820, 660};

	typedef enum logic {ST_CLEAR, ST_RUN} ltsd_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ltsd_req_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} ltsd_rsp_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] idx;
		logic [8:0] level;
	} ltsd_scale_t;

endpackage

/* File: hdl/ltsd_regmem.sv */
`timescale 1ns/1ps
module ltsd_regmem (
	// clock
	input  wire logic       mclk_in,
	input  wire logic       ce_in,
	// write port
	input  wire logic       wr_en_in,
	input  wire logic [6:0] wr_addr_in,
	input  wire logic [7:0] wr_data_in,
	// two registered read ports
	input  wire logic [6:0] rd_a_addr_in,
	output logic      [7:0] rd_a_data_out,
	input  wire logic [6:0] rd_b_addr_in,
	output logic      [7:0] rd_b_data_out
);
	logic [7:0] mem [128];

	// no reset here: the owner walks zeros through every entry
	always_ff @(posedge mclk_in) begin
		if (ce_in) begin
			if (wr_en_in) begin
				mem[wr_addr_in] <= wr_data_in;
			end
			rd_a_data_out <= mem[rd_a_addr_in];
			rd_b_data_out <= mem[rd_b_addr_in];
		end
	end
endmodule

/* File: tb/led_thermal_spread_dc_control_test.sv */
`timescale 1ns/1ps
module led_thermal_spread_dc_control_test;
	import ltsd_pkg::*;
	localparam int START_T [4] = '{140, 120, 100, 90};
	localparam int DER [4]     = '{256, 192, 141, 77};
	localparam int SPAN_T [4]  = '{80, 240, 384, 544};
	localparam int PER [4]     = '{2200, 2400, 2600, 2800};
	logic               mclk_in         = 1'b0;
	logic               rst_in          = 1'b1;
	logic               shutdown_pin_in = 1'b0;
	logic [7:0]         die_temp_in     = 8'h19;
	logic               ce              = 1'b1;
	ltsd_req_t          req;
	ltsd_rsp_t          rsp;
	logic               busy;
	logic [17:0]        out_a;
	logic [17:0]        out_b;
	logic [7:0]         gcur;
	ltsd_scale_t        scl;
	logic               otemp;
	logic               tick;
	logic signed [11:0] trim;
	int                 errors    = 0;
	int                 cmp_count = 0;
	int                 on_cnt [18];
	always #10 mclk_in = ~mclk_in;
	ltsd_ctrl #(.SPREAD_CYC_0(PER[0]), .SPREAD_CYC_1(PER[1]),
		.SPREAD_CYC_2(PER[2]), .SPREAD_CYC_3(PER[3])) dut_u (
		.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce), .req_in(req),
		.rsp_out(rsp), .busy_out(busy), .shutdown_pin_in(shutdown_pin_in),
		.die_temp_in(die_temp_in), .out_a_out(out_a), .out_b_out(out_b),
		.global_current_out(gcur), .chan_scale_out(scl), .over_temp_out(otemp),
		.osc_tick_out(tick), .osc_trim_out(trim));
	ltsd_host host_u (.mclk_in(mclk_in), .rsp_in(rsp), .busy_in(busy), .req_out(req));
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic wait_idle();
		for (int n = 0; n < 400 && busy !== 1'b0; n++) cyc(1);
		chk(busy, 1'b0);
	endtask
	task automatic count_on(input int n);
		for (int c = 0; c < 18; c++) on_cnt[c] = 0;
		repeat (n) begin
			cyc(1);
			for (int c = 0; c < 18; c++) on_cnt[c] += (out_a[c] === 1'b1);
		end
	endtask
	task automatic chk_clear();
		logic [7:0] d;
		logic [7:0] al [4] = '{ADDR_TEMP, ADDR_SPREAD, ADDR_GLOBAL, ADDR_CTRL};
		for (int i = 0; i < 4; i++) begin
			host_u.rd(al[i], d);
			chk(d, 8'h00);
		end
		chk(gcur, 8'h00);
		chk(out_a, 18'h0);
		chk(out_b, 18'h0);
	endtask
	task automatic t_temp();
		logic [7:0] d;
		for (int s = 0; s < 4; s++) for (int h = 0; h < 2; h++) begin
			host_u.wr(ADDR_TEMP, {6'h10, s[1:0]});
			@(posedge mclk_in);
			die_temp_in <= 8'(START_T[s] + h);
			cyc(8);
			host_u.rd_temp(s[1:0], 2'b01, d);
			chk(d, {2'b01, 1'b0, h[0], 2'b00, s[1:0]});
			chk(otemp, h[0]);
		end
	endtask
	task automatic t_derate();
		host_u.wr(ADDR_GLOBAL, 8'hc8);
		@(posedge mclk_in);
		die_temp_in <= 8'hc8;
		for (int d = 0; d < 4; d++) begin
			host_u.wr(ADDR_TEMP, {d[1:0], 6'h00});
			cyc(4);
			chk(gcur, 18'((200 * DER[d]) >> 8));
		end
		@(posedge mclk_in);
		die_temp_in <= 8'h19;
		cyc(8);
		chk(gcur, 8'hc8);
	endtask
	task automatic t_spread();
		logic [7:0] d;
		int t0, t1, n;
		logic signed [11:0] pv;
		for (int c = 0; c < 4; c++) begin
			host_u.wr(ADDR_SPREAD, {4'h1, c[1:0], c[1:0]});
			host_u.rd(ADDR_SPREAD, d);
			chk(d, {4'h1, c[1:0], c[1:0]});
			t0 = -1;
			t1 = -1;
			pv = trim;
			for (int i = 0; i < 2 * PER[c] + 50; i++) begin
				cyc(1);
				if (trim == 12'(SPAN_T[c]) && pv != 12'(SPAN_T[c])) begin
					if (t0 < 0) t0 = i;
					else if (t1 < 0) t1 = i;
				end
				pv = trim;
			end
			chk(18'(t1 - t0), 18'(PER[c]));
		end
		// the sweep must stand still while the clock enable is low
		@(posedge mclk_in);
		ce <= 1'b0;
		cyc(1);
		pv = trim;
		cyc(50);
		chk(trim, pv);
		@(posedge mclk_in);
		ce <= 1'b1;
		host_u.wr(ADDR_SPREAD, 8'h00);
		cyc(4);
		chk(trim, 18'h0);
		n = 0;
		repeat (1000) begin
			cyc(1);
			n += (tick === 1'b1);
		end
		// a fractional step rate may land one tick either side
		chk(n >= 319 && n <= 321, 1'b1);
	endtask
	task automatic t_pwm();
		host_u.wr(ADDR_CTRL, 8'h01);
		host_u.wr(8'h01, 8'h01);
		host_u.wr(8'h19, 8'h80);
		cyc(300);
		count_on(300);
		chk(on_cnt[6], 18'h0);
		host_u.wr(ADDR_UPDATE, TRIGGER);
		cyc(300);
		count_on(1000);
		chk(on_cnt[0], 18'h0);
		chk(on_cnt[12], 18'h0);
		chk(on_cnt[6] >= 350 && on_cnt[6] <= 650, 1'b1);
		host_u.wr(ADDR_SPREAD, 8'ha0);
		cyc(4);
		count_on(200);
		chk(on_cnt[0], 18'd200);
		chk(on_cnt[5], 18'd200);
		chk(on_cnt[17], 18'd200);
		chk(out_b, 18'h3f03f);
	endtask
	task automatic t_scale();
		int n;
		host_u.wr(8'h54, 8'h33);
		host_u.wr(8'h55, 8'h11);
		// let one whole sweep pass so no report mixes old and new halves
		cyc(110);
		for (n = 0; n < 300 && !(scl.valid === 1'b1 && scl.idx === 5'd5); n++) cyc(1);
		chk(scl.level, 9'h044);
	endtask
	task automatic t_swrst();
		logic [7:0] d;
		host_u.wr(ADDR_SWRST, 8'h55);
		host_u.rd(ADDR_SPREAD, d);
		chk(d, 8'ha0);
		host_u.wr(ADDR_SWRST, RST_VAL);
		cyc(1);
		chk(busy, 1'b1);
		wait_idle();
		chk_clear();
	endtask
	task automatic tally_and_finish();
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// the whole sequence needs about 25000 cycles
	initial begin
		#1000000;
		errors++;
		tally_and_finish();
	end
	initial begin
		repeat (6) @(posedge mclk_in);
		rst_in          <= 1'b0;
		shutdown_pin_in <= 1'b1;
		cyc(1);
		wait_idle();
		chk_clear();
		t_temp();
		t_derate();
		t_spread();
		t_pwm();
		t_scale();
		t_swrst();
		tally_and_finish();
	end
endmodule

/* File: tb/ltsd_host.sv */
`timescale 1ns/1ps
module ltsd_host (
	// clock
	input  wire logic                mclk_in,
	// register port
	input  wire ltsd_pkg::ltsd_rsp_t rsp_in,
	input  wire logic                busy_in,
	output ltsd_pkg::ltsd_req_t      req_out
);
	import ltsd_pkg::*;
	initial req_out = '0;
	// writes wait out the clear walk, else they vanish silently
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (busy_in !== 1'b0 && n < 400) begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		@(posedge mclk_in);
		req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk_in);
		req_out <= '0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		d = 'x;
		@(posedge mclk_in);
		req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk_in);
		req_out <= '0;
		for (int n = 0; n < 6; n++) begin
			@(posedge mclk_in);
			#1;
			if (rsp_in.valid === 1'b1) begin
				d = rsp_in.data;
				break;
			end
		end
	endtask
	// the flag is only trusted right after the fields are rewritten
	task automatic rd_temp(input logic [1:0] st, input logic [1:0] dr, output logic [7:0] d);
		wr(ADDR_TEMP, {dr, 4'h0, st});
		rd(ADDR_TEMP, d);
	endtask
endmodule
